// *** design/tmr_pkg.sv ***
// Shared constants and types for the normal and fast PWM timer block.
package tmr_pkg;
	localparam int CW = 10;
	localparam int NCH = 3;
	localparam int NPIN = 2 * NCH;
	localparam int AW = 8;
	localparam logic [CW-1:0] CNT_MAX = 10'h3ff;

	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_COUNT = 8'h04;
	localparam logic [AW-1:0] OFS_TOP = 8'h08;
	localparam logic [AW-1:0] OFS_CMP0 = 8'h0c;
	localparam logic [AW-1:0] OFS_CMP1 = 8'h10;
	localparam logic [AW-1:0] OFS_CMP2 = 8'h14;
	localparam logic [AW-1:0] OFS_OUTSET = 8'h18;
	localparam logic [AW-1:0] OFS_STATUS = 8'h1c;
	localparam logic [AW-1:0] OFS_PORT = 8'h20;

	localparam int CTRL_PWM_BIT = 0;
	localparam int CTRL_WGM_BIT = 1;
	localparam int CTRL_DIV_LSB = 8;
	localparam int DIV_W = 8;
	localparam int OUTSET_FORCE_LSB = 8;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_WAVE_LSB = 4;
	localparam int STAT_OC_LSB = 8;
	localparam int PORT_DDR_LSB = 8;

	localparam logic [1:0] SET_OFF = 2'h0;
	localparam logic [1:0] SET_TOGGLE = 2'h1;
	localparam logic [1:0] SET_CLEAR = 2'h2;
	localparam logic [1:0] SET_SET = 2'h3;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [AW-1:0] paddr;
		logic [31:0] pwdata;
	} tmr_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tmr_apb_rsp_t;

	typedef struct packed {
		logic [NPIN-1:0] level;
		logic [NPIN-1:0] oe_n;
	} tmr_pins_t;

	typedef struct packed {
		tmr_apb_rsp_t rsp;
		tmr_pins_t pins;
		logic pwm_enable_bit;
		logic waveform_mode_select;
		logic [DIV_W-1:0] tick_div;
		logic [DIV_W-1:0] div_cnt;
		logic [CW-1:0] timer_count;
		logic [CW-1:0] top_compare_value;
		logic [NCH-1:0][CW-1:0] channel_compare_value;
		logic [NCH-1:0][1:0] compare_output_setting;
		logic [NCH-1:0] channel_waveform_output;
		logic [NCH-1:0] channel_compare_output;
		logic overflow_flag;
		logic match_block;
		logic [NPIN-1:0] port_data;
		logic [NPIN-1:0] port_dir;
	} tmr_state_t;

	localparam tmr_state_t ST_RESET = '{
		pins: '{level: '0, oe_n: '1},
		default: '0
	};
endpackage

// *** design/tmr_core.sv ***
// Timer with up-counter, programmable TOP, three compare channels and pin override.
//
// What this block does
// - Counting sequence set only by TOP, the same in both modes.
// - Normal mode counts zero to TOP, restarts.
// - Normal toggle setting inverts output on match.
// - Normal: clear setting lows, set setting highs.
// - Counter returns to zero tick after TOP.
// - Normal overflow flag sets when counter zeroes.
// - Overflow flag cleared when software services it.
// - Counter writable at any time in Normal.
// - Toggle frequency is tick rate over 2(1+TOP).
// - Normal: true pin disconnected, complement pin connected when setting non-zero.
// - Compare output reaches pin only when output.
// - Fast PWM single slope zero to TOP.
// - Fast PWM action follows output setting field.
// - Bottom transition in the wrap tick.
// - Fast PWM overflow flag sets reaching TOP.
// - Extreme compare values give spike or constant.
// - Fast PWM overrides port when setting non-zero.
// - Setting 01 drives both pins, others complement.
// - Compare output lags waveform one tick.
// - Setting change acts at next compare match.
// - Counter write blocks matches next tick.
`timescale 1ns/10ps
`default_nettype none

module tmr_core
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic [NPIN-1:0] pin_level,
	output logic [NPIN-1:0] pin_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Waveform after a compare match for the given output setting.
	function automatic logic match_action(input logic [1:0] setting, input logic wave);
		logic r;
		r = wave;
		unique case (setting)
			SET_OFF: r = wave;
			SET_TOGGLE: r = ~wave;
			SET_CLEAR: r = 1'b0;
			SET_SET: r = 1'b1;
		endcase
		return r;
	endfunction

	// Fast PWM waveform after the wrap from TOP to zero.
	function automatic logic bottom_action(input logic [1:0] setting, input logic wave);
		logic r;
		r = wave;
		unique case (setting)
			SET_OFF: r = wave;
			SET_TOGGLE: r = 1'b1;
			SET_CLEAR: r = 1'b1;
			SET_SET: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [AW-1:0] cmp_ofs(input int ch);
		logic [AW-1:0] r;
		r = OFS_CMP0;
		if (ch == 1) begin
			r = OFS_CMP1;
		end else if (ch == 2) begin
			r = OFS_CMP2;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	tmr_apb_req_t req;
	tmr_state_t st_reg;
	tmr_state_t st_next;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	assign pready = st_reg.rsp.pready;
	assign pslverr = st_reg.rsp.pslverr;
	assign prdata = st_reg.rsp.prdata;
	assign pin_level = st_reg.pins.level;
	assign pin_oe_n = st_reg.pins.oe_n;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		logic setup;
		logic wr;
		logic tick;
		logic wrap;
		logic fast;
		logic mapped;
		logic ovf_set;
		logic ovf_clr;
		logic [CW-1:0] cnt_inc;
		logic [31:0] rd;
		logic [NCH-1:0] force_hit;
		logic match;
		logic conn_true;
		logic conn_comp;
		logic comp_val;
		setup = 1'b0;
		wr = 1'b0;
		tick = 1'b0;
		wrap = 1'b0;
		fast = 1'b0;
		mapped = 1'b0;
		ovf_set = 1'b0;
		ovf_clr = 1'b0;
		cnt_inc = '0;
		rd = '0;
		force_hit = '0;
		match = 1'b0;
		conn_true = 1'b0;
		conn_comp = 1'b0;
		comp_val = 1'b0;
		st_next = st_reg;

		// Tick divider: zero stops the timer, n gives one tick every n clocks.
		if (st_reg.tick_div != '0) begin
			if (st_reg.div_cnt + 8'h01 >= st_reg.tick_div) begin
				st_next.div_cnt = '0;
				tick = 1'b1;
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 8'h01;
			end
		end else begin
			st_next.div_cnt = '0;
		end

		// Counting depends only on TOP and the tick, never on the mode bits or the output settings.
		fast = st_reg.pwm_enable_bit;
		wrap = st_reg.timer_count == st_reg.top_compare_value;
		cnt_inc = st_reg.timer_count + 10'h001;
		if (tick) begin
			if (wrap) begin
				st_next.timer_count = '0;
			end else begin
				st_next.timer_count = cnt_inc;
			end
			if (fast) begin
				ovf_set = st_next.timer_count == st_reg.top_compare_value;
			end else begin
				ovf_set = wrap;
			end
			// The dead-time stage runs with zero delay here, so it only resynchronises.
			st_next.channel_compare_output = st_reg.channel_waveform_output;
			st_next.match_block = 1'b0;
		end

		for (int ch = 0; ch < NCH; ch++) begin
			// A match in the tick after a counter write is dropped so that a compare
			// value equal to the new count does not fire immediately.
			match = tick && !st_reg.match_block &&
				st_reg.timer_count == st_reg.channel_compare_value[ch];
			if (tick) begin
				if (fast) begin
					// Bottom action wins when the match coincides with the wrap.
					if (wrap) begin
						st_next.channel_waveform_output[ch] = bottom_action(
							st_reg.compare_output_setting[ch],
							st_reg.channel_waveform_output[ch]);
					end else if (match) begin
						st_next.channel_waveform_output[ch] = match_action(
							st_reg.compare_output_setting[ch] == SET_TOGGLE ?
							SET_CLEAR : st_reg.compare_output_setting[ch],
							st_reg.channel_waveform_output[ch]);
					end
				end else if (match) begin
					st_next.channel_waveform_output[ch] = match_action(
						st_reg.compare_output_setting[ch],
						st_reg.channel_waveform_output[ch]);
				end
			end
		end

		// APB: the answer is prepared in the setup cycle and shown in the access cycle.
		setup = req.psel && !req.penable;
		wr = req.psel && req.penable && req.pwrite && st_reg.rsp.pready;
		mapped = 1'b0;
		rd = '0;
		unique case (req.paddr)
			OFS_CTRL: begin
				mapped = 1'b1;
				rd[CTRL_PWM_BIT] = st_reg.pwm_enable_bit;
				rd[CTRL_WGM_BIT] = st_reg.waveform_mode_select;
				rd[CTRL_DIV_LSB +: DIV_W] = st_reg.tick_div;
			end
			OFS_COUNT: begin
				mapped = 1'b1;
				rd[CW-1:0] = st_reg.timer_count;
			end
			OFS_TOP: begin
				mapped = 1'b1;
				rd[CW-1:0] = st_reg.top_compare_value;
			end
			OFS_OUTSET: begin
				mapped = 1'b1;
				rd[2*NCH-1:0] = st_reg.compare_output_setting;
			end
			OFS_STATUS: begin
				mapped = 1'b1;
				rd[STAT_OVF_BIT] = st_reg.overflow_flag;
				rd[STAT_WAVE_LSB +: NCH] = st_reg.channel_waveform_output;
				rd[STAT_OC_LSB +: NCH] = st_reg.channel_compare_output;
			end
			OFS_PORT: begin
				mapped = 1'b1;
				rd[NPIN-1:0] = st_reg.port_data;
				rd[PORT_DDR_LSB +: NPIN] = st_reg.port_dir;
			end
			default: begin
				for (int ch = 0; ch < NCH; ch++) begin
					if (req.paddr == cmp_ofs(ch)) begin
						mapped = 1'b1;
						rd[CW-1:0] = st_reg.channel_compare_value[ch];
					end
				end
			end
		endcase
		st_next.rsp.pready = setup;
		st_next.rsp.pslverr = setup && !mapped;
		st_next.rsp.prdata = (setup && mapped && !req.pwrite) ? rd : '0;

		if (wr && mapped) begin
			unique case (req.paddr)
				OFS_CTRL: begin
					st_next.pwm_enable_bit = req.pwdata[CTRL_PWM_BIT];
					st_next.waveform_mode_select = req.pwdata[CTRL_WGM_BIT];
					st_next.tick_div = req.pwdata[CTRL_DIV_LSB +: DIV_W];
				end
				OFS_COUNT: begin
					st_next.timer_count = req.pwdata[CW-1:0];
					st_next.match_block = 1'b1;
				end
				OFS_TOP: begin
					st_next.top_compare_value = req.pwdata[CW-1:0];
				end
				OFS_OUTSET: begin
					st_next.compare_output_setting = req.pwdata[2*NCH-1:0];
					force_hit = req.pwdata[OUTSET_FORCE_LSB +: NCH];
				end
				OFS_STATUS: begin
					ovf_clr = req.pwdata[STAT_OVF_BIT];
				end
				OFS_PORT: begin
					st_next.port_data = req.pwdata[NPIN-1:0];
					st_next.port_dir = req.pwdata[PORT_DDR_LSB +: NPIN];
				end
				default: begin
					for (int ch = 0; ch < NCH; ch++) begin
						if (req.paddr == cmp_ofs(ch)) begin
							st_next.channel_compare_value[ch] = req.pwdata[CW-1:0];
						end
					end
				end
			endcase
		end

		// Force strobes apply the new match action at once, Normal mode only.
		if (!fast) begin
			for (int ch = 0; ch < NCH; ch++) begin
				if (force_hit[ch]) begin
					st_next.channel_waveform_output[ch] = match_action(
						req.pwdata[2*ch +: 2], st_reg.channel_waveform_output[ch]);
				end
			end
		end

		// Hardware set beats a software clear in the same cycle.
		if (ovf_set) begin
			st_next.overflow_flag = 1'b1;
		end else if (ovf_clr) begin
			st_next.overflow_flag = 1'b0;
		end

		// Pin override: pins 2ch (true) and 2ch+1 (complement) of each channel.
		for (int ch = 0; ch < NCH; ch++) begin
			conn_true = fast && st_reg.compare_output_setting[ch] == SET_TOGGLE;
			conn_comp = st_reg.compare_output_setting[ch] != SET_OFF;
			comp_val = conn_true ? ~st_reg.channel_compare_output[ch] :
				st_reg.channel_compare_output[ch];
			st_next.pins.oe_n[2*ch] = ~st_reg.port_dir[2*ch];
			st_next.pins.oe_n[2*ch+1] = ~st_reg.port_dir[2*ch+1];
			st_next.pins.level[2*ch] = conn_true ?
				st_reg.channel_compare_output[ch] : st_reg.port_data[2*ch];
			st_next.pins.level[2*ch+1] = conn_comp ?
				comp_val : st_reg.port_data[2*ch+1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

`default_nettype wire

// *** verif/tmr_checker.sv ***
// Port checker for the timer block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module tmr_checker
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic [NPIN-1:0] pin_level,
	input wire logic [NPIN-1:0] pin_oe_n
);
	logic wp;
	// Only a landed write to the port register may move the pin enables.
	assign wp = psel && penable && pwrite && paddr == OFS_PORT;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_map: assert property (pready |-> pslverr ==
		($past(paddr) > OFS_PORT || $past(paddr[1:0]) != 2'h0))
		else $error("pslverr wrong");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	chk_rdata_quiet: assert property (!pready || $past(pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero");
	chk_oe_cause: assert property ($changed(pin_oe_n) |-> $past(wp) || $past(wp, 2))
		else $error("pin enable moved alone");
	chk_reset_state: assert property (disable iff (1'b0)
		!nrst |=> pin_oe_n == '1 && pin_level == '0 && !pready)
		else $error("reset state wrong");
	cover property (pready && pslverr);
	cover property (pready && !pwrite);
	cover property ($changed(pin_oe_n));
endmodule
bind tmr_core tmr_checker chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .pin_level(pin_level), .pin_oe_n(pin_oe_n));
`default_nettype wire

// *** verif/tmr_load.sv ***
// Load model on the timer port pins.
`timescale 1ns/10ps
`default_nettype none
module tmr_load
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic [NPIN-1:0] level,
	input wire logic [NPIN-1:0] oe_n,
	output logic [NPIN-1:0] pad
);
	logic [NPIN-1:0] last_reg = '0;
	// Undriven pins have no pull, so they show the inverse of the last driven level;
	// a bench that reads a released pin then sees a wrong value, not a stale one.
	assign pad = (level & ~oe_n) | (~last_reg & oe_n);
	always_ff @(posedge clk) begin
		last_reg <= (level & ~oe_n) | (last_reg & oe_n);
	end
endmodule
`default_nettype wire

// *** verif/test_timer_normal_fast_pwm_modes.sv ***
// Self-checking bench for the timer block driven over APB.
`timescale 1ns/10ps
`default_nettype none
module test_timer_normal_fast_pwm_modes;
	import tmr_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic [NPIN-1:0] pin_level;
	logic [NPIN-1:0] pin_oe_n;
	logic [NPIN-1:0] pad;
	logic [31:0] rv;
	logic ev;
	int miscompares = 0;
	int samples_checked = 0;
	int h0, h1, t1;
	tmr_core DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .pin_level(pin_level), .pin_oe_n(pin_oe_n));
	tmr_load LOAD (.clk(clk), .level(pin_level), .oe_n(pin_oe_n), .pad(pad));
	initial begin
		forever #4 clk = ~clk;
	end
	task finish_test;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task ap(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// The registered answer is looked at mid-cycle, where it has settled; the request
		// is only released at the rising edge that follows, at which the slave samples it.
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (pready === 1'b1) break;
		end
		rv = prdata;
		ev = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			miscompares++;
			finish_test;
		end
	endtask
	// Counts over 16 clocks, a whole number of periods for the TOP values used here.
	task ms;
		logic p;
		h0 = 0;
		h1 = 0;
		t1 = 0;
		// Pins are sampled mid-cycle so that the pin registers never race the bench.
		@(negedge clk);
		p = pad[1];
		repeat (16) begin
			@(negedge clk);
			h0 += pad[0];
			h1 += pad[1];
			t1 += int'(pad[1] != p);
			p = pad[1];
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		ap(0, OFS_STATUS, 0);
		cmp(rv, 32'h0);
		ap(0, OFS_COUNT, 0);
		cmp(rv, 32'h0);
		ap(0, 8'h24, 0);
		cmp(32'(ev), 32'h1);
		ap(1, OFS_PORT, 32'h3f3f);
		ap(1, OFS_OUTSET, 32'h1);
		repeat (2) @(posedge clk);
		cmp(32'(pin_oe_n), 32'h0);
		for (int t = 1; t < 4; t += 2) begin
			ap(1, OFS_TOP, 32'(t));
			ap(1, OFS_CTRL, 32'h100);
			repeat (8) @(posedge clk);
			ms;
			cmp(32'(t1), 32'(16 / (t + 1)));
			cmp(32'(h0), 32'd16);
		end
		ap(1, OFS_CTRL, 32'h0);
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h1, 32'h1);
		ap(1, OFS_STATUS, 32'h1);
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h1, 32'h0);
		ap(1, OFS_COUNT, 32'h2);
		ap(0, OFS_COUNT, 0);
		cmp(rv, 32'h2);
		for (int s = 3; s > 1; s--) begin
			ap(1, OFS_OUTSET, 32'(s));
			ap(1, OFS_CTRL, 32'h100);
			repeat (8) @(posedge clk);
			ap(1, OFS_CTRL, 32'h0);
			ap(0, OFS_STATUS, 0);
			cmp(32'(rv[4]), 32'(s == 3));
		end
		ap(1, OFS_STATUS, 32'h1);
		ap(1, OFS_CMP0, 32'h2);
		for (int s = 0; s < 4; s++) begin
			ap(1, OFS_OUTSET, 32'(s));
			ap(1, OFS_CTRL, 32'h101);
			repeat (8) @(posedge clk);
			ms;
			cmp(32'(h0), s == 1 ? 32'd12 : 32'd16);
			cmp(32'(h1), s[0] ? 32'd4 : (s == 2 ? 32'd12 : 32'd16));
		end
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h1, 32'h1);
		// A slow tick, one every 16 clocks, lets the bench look between single ticks.
		ap(1, OFS_CTRL, 32'h0);
		ap(1, OFS_OUTSET, 32'h102);
		ap(1, OFS_OUTSET, 32'h3);
		ap(1, OFS_COUNT, 32'h2);
		ap(1, OFS_CTRL, 32'h1000);
		repeat (24) @(posedge clk);
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h110, 32'h0);
		repeat (64) @(posedge clk);
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h110, 32'h10);
		repeat (16) @(posedge clk);
		ap(0, OFS_STATUS, 0);
		cmp(rv & 32'h110, 32'h110);
		ap(1, OFS_PORT, 32'h0);
		repeat (2) @(posedge clk);
		cmp(32'(pin_oe_n), 32'h3f);
		finish_test;
	end
endmodule
`default_nettype wire
